// [design/cdd_codec_datapath.sv]
/*
 * Codec digital datapath: record decimator and word formatter, playback
 * interpolator and sigma-delta modulator, control bits, serial port and
 * an APB register slave.
 * Assumes pclk is the device master clock, the record modulator bit is
 * produced on pclk, and the serial clock arrives asynchronously.
 */
// Functional notes
// - Record path takes a one-bit modulator stream at master clock over eight.
// - Third-order sinc decimator lowers rate eight to 256, one bit to 15.
// - Decimator and interpolator both are the cube of a 32-tap moving sum.
// - Record words two's complement; 16-bit mode shifts left, LSB zero.
// - At or above positive full scale the saturated code with LSB one is sent.
// - Mixed mode gives 15-bit samples, frame MSB flags control versus data.
// - Playback words are two's complement, 7fff top and 8000 bottom.
// - Interpolator raises playback words from rate 256 up to rate eight.
// - Without a new playback word the held word is used again.
// - Bypass bit sends the playback word straight to the modulator.
// - Playback modulator makes a one-bit stream at master clock over eight.
// - Three-bit gain field selects +6 dB down to -15 dB in 3 dB steps.
// - Mute bit silences the differential playback output.
// - Reference select bit chooses 1.2 V when clear, 2.4 V when set.
// - Reference output enable drives the buffered reference pin.
// - Serial words both ways shift at serial clock rate, MSB first.
// - First control register bit 0 selects data mode, bit 1 mixed mode when bit 0 is set.
`timescale 1ns/1ps
`default_nettype none

module cdd_codec_datapath (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Record modulator stream
	input wire logic rec_mod_bit,
	// Serial port
	input wire logic sclk,
	input wire logic sdi,
	output logic sdo,
	output logic sdofs,
	// Playback stream and analog controls
	output logic playback_out_pos,
	output logic playback_out_neg,
	output logic [2:0] out_gain_sel,
	output logic playback_mute,
	output logic ref_level_select,
	output logic ref_output_enable
);
	import cdd_pkg::*;

	cdd_state_s s_q;
	cdd_state_s s_d;

	logic tick8;
	logic tsamp;
	logic data_mode;
	logic mixed_mode;
	logic bypass;
	logic sck_rise;
	logic sck_fall;
	logic [15:0] c1;
	logic [15:0] c2;
	logic [15:0] c3;
	logic [25:0] pw;
	logic [25:0] k1;
	logic [25:0] k2;
	logic [25:0] k3;
	logic [15:0] mod_x;
	logic signed [17:0] sum;
	logic mbit;
	logic [15:0] rx_word;
	logic apb_acc;
	logic [2:0] reg_sel;

	// --------------------------------------------------------------
	// Elaboration checks
	// --------------------------------------------------------------
	// The sample interval must hold exactly 32 modulator ticks for the sinc nulls
	if ((int'(SAMPLE_LAST) + 1) != 32 * (int'(OSR_LAST) + 1)) begin
		$error("sample interval is not 32 modulator ticks");
	end
	// The interpolator slice must end at the top of its integrator
	if (INTERP_SHIFT + 16 != $bits(pw)) begin
		$error("interpolator gain shift does not fit the integrator width");
	end
	// The frame logic counts sixteen bit times
	if (int'(WORD_LAST) != 15) begin
		$error("serial word length is not sixteen bits");
	end

	// --------------------------------------------------------------
	// Pin synchroniser filter
	// --------------------------------------------------------------
	// A level counts only once the second and third flops agree, so a
	// metastable sample can never pass for a serial clock edge
	function automatic logic sync_level(input logic [2:0] taps, input logic held);
		if (taps[1] == taps[2]) begin
			sync_level = taps[2];
		end else begin
			sync_level = held;
		end
	endfunction

	// --------------------------------------------------------------
	// Register decode, shared by the read and the write side
	// --------------------------------------------------------------
	function automatic logic [2:0] reg_index(input logic [7:0] a);
		unique case (a)
			OFF_CTRL_FIRST: reg_index = 3'h0;
			OFF_CTRL_THIRD: reg_index = 3'h1;
			OFF_CTRL_FOURTH: reg_index = 3'h2;
			OFF_CTRL_FIFTH: reg_index = 3'h3;
			OFF_PLAY_WORD: reg_index = 3'h4;
			OFF_REC_WORD: reg_index = 3'h5;
			default: reg_index = 3'h7;
		endcase
	endfunction

	// --------------------------------------------------------------
	// Record word formatting
	// --------------------------------------------------------------
	function automatic logic [15:0] fmt_rec(input logic [15:0] v, input logic mixed);
		logic signed [16:0] cen;
		logic sat;
		cen = $signed({1'b0, v}) - DEC_MID;
		sat = (cen >= DEC_FS);
		if (mixed) begin
			fmt_rec = sat ? SAT_15 : {1'b0, cen[14:0]};
		end else if (sat) begin
			fmt_rec = SAT_16;
		end else begin
			fmt_rec = {cen[14:0], 1'b0};
		end
	endfunction

	// --------------------------------------------------------------
	// Next-state logic
	// --------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		tick8 = (s_q.cnt[2:0] == OSR_LAST);
		tsamp = (s_q.cnt == SAMPLE_LAST);
		data_mode = s_q.ctl_first[MODE_DATA_BIT];
		mixed_mode = data_mode & s_q.ctl_first[MODE_MIXED_BIT];
		bypass = s_q.ctl_fifth[BYPASS_BIT];
		s_d.cnt = s_q.cnt + 8'h01;

		// Serial clock and data: three flops, level accepted once the last two agree
		s_d.sck = {s_q.sck[1:0], sclk};
		s_d.sds = {s_q.sds[1:0], sdi};
		s_d.sck_lvl = sync_level(s_q.sck, s_q.sck_lvl);
		s_d.sdi_lvl = sync_level(s_q.sds, s_q.sdi_lvl);
		sck_rise = s_d.sck_lvl & ~s_q.sck_lvl;
		sck_fall = ~s_d.sck_lvl & s_q.sck_lvl;

		// Decimator integrators run once per modulator bit
		if (tick8) begin
			s_d.di[0] = s_q.di[0] + {15'h0000, rec_mod_bit};
			s_d.di[1] = s_q.di[1] + s_q.di[0];
			s_d.di[2] = s_q.di[2] + s_q.di[1];
		end
		// Combs at the output rate; wrap-around arithmetic keeps them exact
		c1 = s_q.di[2] - s_q.dd[0];
		c2 = c1 - s_q.dd[1];
		c3 = c2 - s_q.dd[2];
		if (tsamp) begin
			s_d.dd[0] = s_q.di[2];
			s_d.dd[1] = c1;
			s_d.dd[2] = c2;
			s_d.rec = fmt_rec(c3, mixed_mode);
		end

		// Interpolator combs take the held word every interval
		pw = {{10{s_q.play[15]}}, s_q.play};
		k1 = pw - s_q.ie[0];
		k2 = k1 - s_q.ie[1];
		k3 = k2 - s_q.ie[2];
		if (tsamp) begin
			s_d.ie[0] = pw;
			s_d.ie[1] = k1;
			s_d.ie[2] = k2;
		end
		// Zero stuffing: the comb output enters only on the interval tick
		if (tick8) begin
			s_d.ii[0] = s_q.ii[0] + (tsamp ? k3 : 26'h0000000);
			s_d.ii[1] = s_q.ii[1] + s_q.ii[0];
			s_d.ii[2] = s_q.ii[2] + s_q.ii[1];
		end

		// First-order modulator; error stays bounded for any 16-bit input
		mod_x = bypass ? s_q.play : s_q.ii[2][INTERP_SHIFT +: 16];
		sum = $signed(s_q.err) + $signed({{2{mod_x[15]}}, mod_x});
		mbit = ~sum[17];
		if (tick8) begin
			s_d.err = 18'(sum - (mbit ? SDM_POS : SDM_NEG));
			s_d.pos = mbit & ~s_q.ctl_fourth[MUTE_BIT];
			s_d.neg = ~mbit & ~s_q.ctl_fourth[MUTE_BIT];
		end

		// APB: one wait state, write lands on the completing edge
		apb_acc = psel & penable & s_q.pready;
		reg_sel = reg_index(paddr);
		s_d.pready = psel & penable & ~s_q.pready;
		s_d.pslverr = 1'b0;
		s_d.prdata = 32'h00000000;
		if (psel & penable & ~s_q.pready) begin
			unique case (reg_sel)
				3'h0: s_d.prdata = {24'h000000, s_q.ctl_first};
				3'h1: s_d.prdata = {24'h000000, s_q.ctl_third};
				3'h2: s_d.prdata = {24'h000000, s_q.ctl_fourth};
				3'h3: s_d.prdata = {24'h000000, s_q.ctl_fifth};
				3'h4: s_d.prdata = {16'h0000, s_q.play};
				3'h5: s_d.prdata = {16'h0000, s_q.rec};
				default: s_d.pslverr = 1'b1;
			endcase
		end
		// The record word and unmapped addresses take no write
		if (apb_acc & pwrite) begin
			unique case (reg_sel)
				3'h0: s_d.ctl_first = pwdata[7:0];
				3'h1: s_d.ctl_third = pwdata[7:0];
				3'h2: s_d.ctl_fourth = pwdata[7:0];
				3'h3: s_d.ctl_fifth = pwdata[7:0];
				3'h4: s_d.play = pwdata[15:0];
				default: s_d.ctl_first = s_q.ctl_first;
			endcase
		end

		// Serial port: the codec opens every frame, input shares the register
		rx_word = {s_q.sh[14:0], s_q.sdi_lvl};
		if (tsamp) begin
			s_d.pend = 1'b1;
		end
		unique case (s_q.ser)
			SER_IDLE: begin
				if (sck_rise & s_q.pend) begin
					s_d.pend = tsamp;
					s_d.sh = s_q.rec;
					s_d.sdofs = 1'b1;
					s_d.ser = SER_FRAME;
				end
			end
			SER_FRAME: begin
				if (sck_rise) begin
					s_d.sdofs = 1'b0;
					s_d.sdo = s_q.sh[15];
					s_d.bitcnt = 5'h00;
					s_d.ser = SER_SHIFT;
				end
			end
			SER_SHIFT: begin
				if (sck_rise) begin
					s_d.sdo = s_q.sh[15];
				end
				if (sck_fall) begin
					// Host bits arrive only inside a codec frame
					s_d.sh = rx_word;
					s_d.bitcnt = s_q.bitcnt + 5'h01;
					if (s_q.bitcnt == WORD_LAST) begin
						s_d.ser = SER_IDLE;
						if (mixed_mode) begin
							if (!rx_word[15]) begin
								s_d.play = {rx_word[14:0], 1'b0};
							end
						end else if (data_mode) begin
							s_d.play = rx_word;
						end
					end
				end
			end
		endcase
	end

	// --------------------------------------------------------------
	// State register
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// --------------------------------------------------------------
	// Outputs, all straight from the state register
	// --------------------------------------------------------------
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign sdo = s_q.sdo;
	assign sdofs = s_q.sdofs;
	assign playback_out_pos = s_q.pos;
	assign playback_out_neg = s_q.neg;
	// Code 0 is the loudest setting; the analog gain stage decodes it
	assign out_gain_sel = s_q.ctl_fourth[GAIN_MSB:GAIN_LSB];
	assign playback_mute = s_q.ctl_fourth[MUTE_BIT];
	assign ref_level_select = s_q.ctl_third[REF_LEVEL_BIT];
	assign ref_output_enable = s_q.ctl_third[REF_OUT_BIT];

endmodule

`default_nettype wire

// [design/cdd_pkg.sv]
/*
 * Shared constants and state types for the codec digital datapath.
 * Assumes a single device clock that doubles as the device master clock.
 */
`default_nettype none
package cdd_pkg;

	// --------------------------------------------------------------
	// Register map (byte addresses)
	// --------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL_FIRST = 8'h00;
	localparam logic [7:0] OFF_CTRL_THIRD = 8'h04;
	localparam logic [7:0] OFF_CTRL_FOURTH = 8'h08;
	localparam logic [7:0] OFF_CTRL_FIFTH = 8'h0c;
	localparam logic [7:0] OFF_PLAY_WORD = 8'h10;
	localparam logic [7:0] OFF_REC_WORD = 8'h14;
	localparam logic [7:0] CTRL_RST = 8'h00;

	// --------------------------------------------------------------
	// Field positions
	// --------------------------------------------------------------
	localparam int MODE_DATA_BIT = 0;
	localparam int MODE_MIXED_BIT = 1;
	localparam int REF_OUT_BIT = 6;
	localparam int REF_LEVEL_BIT = 7;
	localparam int GAIN_LSB = 4;
	localparam int GAIN_MSB = 6;
	localparam int MUTE_BIT = 7;
	localparam int BYPASS_BIT = 5;

	// --------------------------------------------------------------
	// Rates and filter figures
	// --------------------------------------------------------------
	localparam logic [2:0] OSR_LAST = 3'h7;
	localparam logic [7:0] SAMPLE_LAST = 8'hff;
	localparam int INTERP_SHIFT = 10;
	localparam logic [4:0] WORD_LAST = 5'h0f;
	localparam logic signed [16:0] DEC_MID = 17'sh04000;
	localparam logic signed [16:0] DEC_FS = 17'sh03fff;
	localparam logic [15:0] SAT_16 = 16'h7fff;
	localparam logic [15:0] SAT_15 = 16'h3fff;
	localparam logic signed [17:0] SDM_POS = 18'sh07fff;
	localparam logic signed [17:0] SDM_NEG = -18'sh08000;

	typedef enum logic [1:0] {SER_IDLE, SER_FRAME, SER_SHIFT} cdd_ser_e;

	typedef struct packed {
		logic [7:0] cnt;
		logic [2:0][15:0] di;
		logic [2:0][15:0] dd;
		logic [15:0] rec;
		logic [7:0] ctl_first;
		logic [7:0] ctl_third;
		logic [7:0] ctl_fourth;
		logic [7:0] ctl_fifth;
		logic [15:0] play;
		logic [2:0][25:0] ie;
		logic [2:0][25:0] ii;
		logic [17:0] err;
		logic pos;
		logic neg;
		logic [2:0] sck;
		logic [2:0] sds;
		logic sck_lvl;
		logic sdi_lvl;
		cdd_ser_e ser;
		logic [15:0] sh;
		logic [4:0] bitcnt;
		logic pend;
		logic sdo;
		logic sdofs;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} cdd_state_s;

	localparam cdd_state_s STATE_RST = '0;

endpackage
`default_nettype wire

// [testbench/cdd_chk.sv]
/*
 * Port checker for the codec datapath, bound to every instance.
 * Assumes one clock, pclk, and the async active-low reset presetn.
 */
`timescale 1ns/1ps
`default_nettype none
module cdd_chk (
	// Clock and bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Stream and controls
	input wire logic sdofs,
	input wire logic playback_out_pos,
	input wire logic playback_out_neg,
	input wire logic [2:0] out_gain_sel,
	input wire logic playback_mute,
	input wire logic ref_level_select,
	input wire logic ref_output_enable
);
	import cdd_pkg::*;
	logic [3:0] mute_run;
	logic wr_done;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign wr_done = psel && penable && pready && pwrite;
	// Mute age, so the one-bit stream gets a full update slot to drain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mute_run <= 4'h0;
		else if (!playback_mute)
			mute_run <= 4'h0;
		else if (mute_run != 4'hf)
			mute_run <= mute_run + 4'h1;
	end
	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	a_ready_follows: assert property (psel && penable && !pready |=> pready) else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	a_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
	a_unmapped_err: assert property (pready && paddr > OFF_REC_WORD |-> pslverr && prdata == 32'h0)
		else $error("unmapped not refused");
	a_gain_follows:
		assert property (wr_done && paddr == OFF_CTRL_FOURTH |=> ##1 out_gain_sel == $past(pwdata[6:4], 2))
		else $error("gain field wrong");
	a_ref_follows:
		assert property (wr_done && paddr == OFF_CTRL_THIRD
			|=> ##1 {ref_level_select, ref_output_enable} == $past(pwdata[7:6], 2)) else $error("ref bits wrong");
	a_mute_silent:
		assert property (mute_run > 4'h9 |-> !playback_out_pos && !playback_out_neg) else $error("mute leaks");
	a_out_exclusive:
		assert property (!(playback_out_pos && playback_out_neg)) else $error("both stream bits high");
	a_frame_width:
		assert property ($rose(sdofs) |=> sdofs [*5] ##[1:6] !sdofs) else $error("frame flag width");
endmodule
bind cdd_codec_datapath cdd_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .sdofs, .playback_out_pos, .playback_out_neg, .out_gain_sel, .playback_mute,
	.ref_level_select, .ref_output_enable);
`default_nettype wire

// [testbench/cdd_host_model.sv]
/*
 * Host serial partner: sends one word per frame and collects the record word.
 * Assumes the codec raises its frame flag just after a serial clock rise.
 */
`timescale 1ns/1ps
`default_nettype none
module cdd_host_model (
	// Serial lines
	output logic sclk,
	output logic sdi,
	input wire logic sdo,
	input wire logic sdofs,
	// Bench side
	input wire logic [15:0] tx_word,
	output logic [15:0] rx_word
);
	logic [15:0] sh, rx;
	logic [4:0] cnt = 5'h0;
	// Runs free: the codec can only open a frame on a rise it sees
	initial begin
		sclk = 0;
		sdi = 0;
		forever #100 sclk = ~sclk;
	end
	always @(posedge sclk) begin
		if (cnt == 5'h0) begin
			// Idle line toggles so a stale bit never passes for data
			sh <= tx_word;
			sdi <= sdofs ? tx_word[15] : ~sdi;
			cnt <= {4'h0, sdofs};
		end else begin
			rx <= {rx[14:0], sdo};
			sh <= {sh[14:0], 1'b0};
			sdi <= (cnt == 5'h10) ? ~sdi : sh[14];
			cnt <= (cnt == 5'h10) ? 5'h0 : cnt + 5'h1;
			if (cnt == 5'h10)
				rx_word <= {rx[14:0], sdo};
		end
	end
endmodule
`default_nettype wire

// [testbench/codec_digital_datapath_tb.sv]
/*
 * Bench for the codec datapath: APB master with queued read checks, host partner.
 * Assumes the checker binds itself from its own file.
 */
`timescale 1ns/1ps
`default_nettype none
module codec_digital_datapath_tb;
	import cdd_pkg::*;
	logic pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0, rec_mod_bit = 0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, sclk, sdi, sdo, sdofs, playback_out_pos, playback_out_neg;
	logic playback_mute, ref_level_select, ref_output_enable;
	logic [2:0] out_gain_sel;
	logic [15:0] tx_word = 16'h0, rx_word;
	logic [15:0] rec_exp [3] = '{16'h7fff, 16'h8000, 16'h3fff};
	logic [32:0] notes [$];
	int n_fail = 0, comparisons = 0, cycles = 0;
	cdd_codec_datapath dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .rec_mod_bit, .sclk, .sdi, .sdo, .sdofs, .playback_out_pos, .playback_out_neg,
		.out_gain_sel, .playback_mute, .ref_level_select, .ref_output_enable);
	cdd_host_model host (.sclk, .sdi, .sdo, .sdofs, .tx_word, .rx_word);
	initial begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No limit of its own: a slave that never answers runs into the bench timeout
		do begin
			@(posedge pclk);
		end while (!pready);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		notes.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic play(input logic [1:0] m, input logic [15:0] t, input logic [15:0] e);
		xfer(1'b1, OFF_CTRL_FIRST, {30'h0, m});
		tx_word <= t;
		repeat (600) @(posedge pclk);
		rd(OFF_PLAY_WORD, {17'h0, e});
	endtask
	// Timeout
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			wrap_up();
		end
	end
	// Read watcher: the oldest note meets each completed read
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite)
			chk("read", {pslverr, prdata}, notes.pop_front());
	end
	// --------------------------------------------------------------
	// Stimulus
	// --------------------------------------------------------------
	initial begin
		int g;
		logic [7:0] v;
		r = $urandom(32'h0902693f);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (g = 0; g < 5; g++)
			rd(8'(4 * g), 33'h0);
		rd(8'h18, {1'b1, 32'h0});
		xfer(1'b1, 8'h20, 32'hff);
		for (g = 0; g < 8; g++) begin
			v = {g[0], 3'(g), 4'h0};
			xfer(1'b1, OFF_CTRL_FOURTH, {24'h0, v});
			repeat (3) @(posedge pclk);
			chk("gain", {30'h0, out_gain_sel}, {30'h0, v[6:4]});
			chk("mute", {32'h0, playback_mute}, {32'h0, v[7]});
			rd(OFF_CTRL_FOURTH, {25'h0, v});
		end
		repeat (4) begin
			v = 8'($urandom);
			xfer(1'b1, OFF_CTRL_THIRD, {24'h0, v});
			repeat (3) @(posedge pclk);
			chk("ref", {31'h0, ref_level_select, ref_output_enable}, {31'h0, v[7:6]});
			rd(OFF_CTRL_THIRD, {25'h0, v});
		end
		xfer(1'b1, OFF_CTRL_FIFTH, 32'h20);
		rd(OFF_CTRL_FIFTH, 33'h20);
		xfer(1'b1, OFF_PLAY_WORD, 32'h8000);
		rd(OFF_PLAY_WORD, 33'h8000);
		// Still muted from the gain sweep; the serial port is in control mode here
		repeat (16) @(posedge pclk);
		chk("muted stream", {31'h0, playback_out_pos, playback_out_neg}, 33'h0);
		xfer(1'b1, OFF_CTRL_FOURTH, 32'h0);
		repeat (16) @(posedge pclk);
		chk("stream at bottom", {31'h0, playback_out_pos, playback_out_neg}, 33'h1);
		xfer(1'b1, OFF_PLAY_WORD, 32'h7fff);
		repeat (16) @(posedge pclk);
		chk("stream at top", {31'h0, playback_out_pos, playback_out_neg}, 33'h2);
		// Through the interpolator a held full-scale word settles back to full scale
		xfer(1'b1, OFF_CTRL_FIFTH, 32'h0);
		repeat (2048) @(posedge pclk);
		chk("filtered stream", {31'h0, playback_out_pos, playback_out_neg}, 33'h2);
		for (g = 0; g < 3; g++) begin
			rec_mod_bit <= (g != 1);
			xfer(1'b1, OFF_CTRL_FIRST, (g == 2) ? 32'h3 : 32'h1);
			repeat (2048) @(posedge pclk);
			rd(OFF_REC_WORD, {17'h0, rec_exp[g]});
			chk("serial record", {17'h0, rx_word}, {17'h0, rec_exp[g]});
		end
		r = $urandom;
		play(2'h3, {1'b0, r[14:0]}, {r[14:0], 1'b0});
		play(2'h3, {1'b1, r[30:16]}, {r[14:0], 1'b0});
		play(2'h1, r[31:16], r[31:16]);
		play(2'h0, r[15:0], r[31:16]);
		wrap_up();
	end
endmodule
`default_nettype wire
